// ### dzr_dac_front.sv
// dac input routing, output mapping, zero flags and automute
module dzr_dac_front #(
  parameter int SW = dzr_pkg::SAMPLE_W,
  parameter int DEPTH = dzr_pkg::FIFO_DEPTH,
  parameter int ZERO_RUN = dzr_pkg::ZERO_RUN,
  parameter int GPO_W = 4
) (
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // primary audio port lanes, one stereo frame per accepted strobe
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [SW-1:0] serialInLaneOneLeft,
  input wire logic [SW-1:0] serialInLaneOneRight,
  input wire logic [SW-1:0] serialInLaneTwoLeft,
  input wire logic [SW-1:0] serialInLaneTwoRight,
  input wire logic [SW-1:0] serialInLaneThreeLeft,
  input wire logic [SW-1:0] serialInLaneThreeRight,
  // mapped dac samples: {dac3 r,l, dac2 r,l, dac1 r,l}
  output logic dacValid,
  input wire logic dacReady,
  output logic [6*SW-1:0] dacData,
  // converter controls and flags
  output logic oversampleRateSelect,
  output logic [2:0] converterPowerDown,
  output logic [2:0] converterSoftMute,
  output logic zeroIndicator,
  output logic [GPO_W-1:0] generalOutputPins
);
  localparam int NDAC = 3;

  logic [dzr_pkg::REG_W-1:0] rxOsr_q;
  logic [dzr_pkg::REG_W-1:0] route_q;
  logic [dzr_pkg::REG_W-1:0] mapZf_q;
  logic [dzr_pkg::REG_W-1:0] pwrMute_q;
  logic [31:0] prdata_q;
  logic zeroIndicator_q;
  logic [GPO_W-1:0] gpo_q;

  logic [7:0] regIdx;
  logic addrHit;
  logic wrEn;
  logic setup;
  logic accept;
  logic [3:0] outputChannelMap;
  logic [2:0] zeroFlagSource;
  logic infiniteZeroAutomuteEn;
  logic [NDAC-1:0] dacZeroFlag;
  logic [NDAC-1:0] autoMuted;
  logic [2*NDAC-1:0] chanZeroRun;
  logic allDacZero;
  logic selFlag;
  logic [6*SW-1:0] mapped;
  logic [SW-1:0] laneL [NDAC];
  logic [SW-1:0] laneR [NDAC];

  // --- apb register access ---
  // word aligned; index is the byte address divided by four
  assign regIdx = paddr[9:2];
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite && addrHit;

  always_comb begin
    case (regIdx)
      dzr_pkg::IDX_RX_OSR,
      dzr_pkg::IDX_ROUTE,
      dzr_pkg::IDX_MAP_ZF,
      dzr_pkg::IDX_PWR_MUTE,
      dzr_pkg::IDX_STATUS: addrHit = (paddr[1:0] == 2'h0);
      default: addrHit = 1'b0;
    endcase
  end

  // zero wait states: slave always ready in the access phase
  assign pready = 1'b1;
  // unmapped or misaligned address answers with an error
  assign pslverr = psel && penable && !addrHit;
  assign prdata = prdata_q;

  // read data captured in the setup phase so it stands for the access
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (regIdx)
        dzr_pkg::IDX_RX_OSR: prdata_q <= 32'(rxOsr_q);
        dzr_pkg::IDX_ROUTE: prdata_q <= 32'(route_q);
        dzr_pkg::IDX_MAP_ZF: prdata_q <= 32'(mapZf_q);
        dzr_pkg::IDX_PWR_MUTE: prdata_q <= 32'(pwrMute_q);
        dzr_pkg::IDX_STATUS: begin
          prdata_q <= 32'({chanZeroRun, autoMuted, dacZeroFlag});
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // receiver format fields are storage only; bit 6 is the osr control
  always_ff @(posedge mclk) begin
    if (reset) begin
      rxOsr_q <= dzr_pkg::RST_RX_OSR;
    end else if (wrEn && regIdx == dzr_pkg::IDX_RX_OSR) begin
      rxOsr_q <= {2'b00, pwdata[dzr_pkg::RX_LOW_W:0]};
    end
  end

  // lane select fields for the three dacs
  always_ff @(posedge mclk) begin
    if (reset) begin
      route_q <= dzr_pkg::RST_ROUTE;
    end else if (wrEn && regIdx == dzr_pkg::IDX_ROUTE) begin
      route_q <= {3'b000, pwdata[3*dzr_pkg::SEL_W-1:0]};
    end
  end

  // output map, flag source and automute enable; bit 8 reads zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      mapZf_q <= dzr_pkg::RST_MAP_ZF;
    end else if (wrEn && regIdx == dzr_pkg::IDX_MAP_ZF) begin
      mapZf_q <= {1'b0, pwdata[7:0]};
    end
  end

  // power-down in bits 2:0, soft mute in bits 5:3
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwrMute_q <= dzr_pkg::RST_PWR_MUTE;
    end else if (wrEn && regIdx == dzr_pkg::IDX_PWR_MUTE) begin
      pwrMute_q <= {3'b000, pwdata[5:0]};
    end
  end

  assign oversampleRateSelect = rxOsr_q[dzr_pkg::OSR_BIT];
  assign outputChannelMap = mapZf_q[dzr_pkg::MAP_LO +: 4];
  assign zeroFlagSource = mapZf_q[dzr_pkg::ZFS_LO +: 3];
  assign infiniteZeroAutomuteEn = mapZf_q[dzr_pkg::IZD_BIT];
  assign converterPowerDown = pwrMute_q[2:0];
  assign converterSoftMute = pwrMute_q[dzr_pkg::MUTE_LO +: 3];

  // --- sample path ---
  // a frame is taken only when the fifo has room, so back-pressure
  // from the dac side stalls the lanes and the zero counters alike
  assign accept = sampleValid && sampleReady;

  assign laneL[0] = serialInLaneOneLeft;
  assign laneR[0] = serialInLaneOneRight;
  assign laneL[1] = serialInLaneTwoLeft;
  assign laneR[1] = serialInLaneTwoRight;
  assign laneL[2] = serialInLaneThreeLeft;
  assign laneR[2] = serialInLaneThreeRight;

  for (genvar d = 0; d < NDAC; d++) begin : g_dac
    logic [1:0] laneSel;
    logic signed [SW-1:0] inL;
    logic signed [SW-1:0] inR;
    logic signed [SW:0] sum;
    logic signed [SW-1:0] avg;
    logic zNextL;
    logic zNextR;
    logic muteNow;

    assign laneSel = route_q[d*dzr_pkg::SEL_W +: dzr_pkg::SEL_W];

    // crossbar: each dac picks any lane independently
    always_comb begin
      case (laneSel)
        dzr_pkg::SEL_LANE1: begin
          inL = laneL[0];
          inR = laneR[0];
        end
        dzr_pkg::SEL_LANE2: begin
          inL = laneL[1];
          inR = laneR[1];
        end
        dzr_pkg::SEL_LANE3: begin
          inL = laneL[2];
          inR = laneR[2];
        end
        // unused code feeds silence rather than a stale lane
        default: begin
          inL = '0;
          inR = '0;
        end
      endcase
    end

    // sign extended sum cannot overflow; arithmetic halve
    assign sum = {inL[SW-1], inL} + {inR[SW-1], inR};
    assign avg = sum[SW:1];

    // per channel zero detectors on the routed samples
    dzr_zero_detect #(
      .W(SW),
      .LIMIT(ZERO_RUN)
    ) u_zdL (
      .mclk(mclk),
      .reset(reset),
      .sampleValid(accept),
      .sample(inL),
      .zeroRun(chanZeroRun[2*d]),
      .zeroNext(zNextL)
    );

    dzr_zero_detect #(
      .W(SW),
      .LIMIT(ZERO_RUN)
    ) u_zdR (
      .mclk(mclk),
      .reset(reset),
      .sampleValid(accept),
      .sample(inR),
      .zeroRun(chanZeroRun[2*d+1]),
      .zeroNext(zNextR)
    );

    // judged on the sample in hand, so the first non-zero one passes
    assign muteNow = infiniteZeroAutomuteEn && zNextL && zNextR;
    // held view of automute for status: both runs complete
    assign autoMuted[d] = infiniteZeroAutomuteEn
      && chanZeroRun[2*d] && chanZeroRun[2*d+1];

    // dac flag: both detectors, or power-down, or soft mute
    assign dacZeroFlag[d] = (chanZeroRun[2*d] && chanZeroRun[2*d+1])
      || converterPowerDown[d] || converterSoftMute[d];

    // left output from the low pair, right from the high pair
    always_comb begin
      case (outputChannelMap[1:0])
        dzr_pkg::MAP_LEFT: mapped[2*d*SW +: SW] = inL;
        dzr_pkg::MAP_RIGHT: mapped[2*d*SW +: SW] = inR;
        dzr_pkg::MAP_AVG: mapped[2*d*SW +: SW] = avg;
        default: mapped[2*d*SW +: SW] = '0;
      endcase
      case (outputChannelMap[3:2])
        dzr_pkg::MAP_LEFT: mapped[(2*d+1)*SW +: SW] = inL;
        dzr_pkg::MAP_RIGHT: mapped[(2*d+1)*SW +: SW] = inR;
        dzr_pkg::MAP_AVG: mapped[(2*d+1)*SW +: SW] = avg;
        default: mapped[(2*d+1)*SW +: SW] = '0;
      endcase
      if (muteNow) begin
        mapped[2*d*SW +: 2*SW] = '0;
      end
    end
  end

  // output buffer between the mapping logic and the converters
  dzr_fifo #(
    .WIDTH(6*SW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(mapped),
    .outValid(dacValid),
    .outReady(dacReady),
    .outData(dacData)
  );

  // --- zero indicator ---
  assign allDacZero = &dacZeroFlag;

  always_comb begin
    case (zeroFlagSource)
      dzr_pkg::ZFS_ALL: selFlag = allDacZero;
      dzr_pkg::ZFS_DAC1: selFlag = dacZeroFlag[0];
      dzr_pkg::ZFS_DAC2: selFlag = dacZeroFlag[1];
      dzr_pkg::ZFS_DAC3: selFlag = dacZeroFlag[2];
      default: selFlag = 1'b0;
    endcase
  end

  // registered pins; one cycle behind the flag, glitch free
  always_ff @(posedge mclk) begin
    if (reset) begin
      zeroIndicator_q <= 1'b0;
      gpo_q <= '0;
    end else begin
      zeroIndicator_q <= selFlag;
      gpo_q <= {GPO_W{selFlag}};
    end
  end

  assign zeroIndicator = zeroIndicator_q;
  assign generalOutputPins = gpo_q;
endmodule

// ### dzr_pkg.sv
// constants for the dac routing and zero detect block
package dzr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RX_OSR = 8'h0c;
  localparam logic [7:0] IDX_ROUTE = 8'h0f;
  localparam logic [7:0] IDX_MAP_ZF = 8'h10;
  localparam logic [7:0] IDX_PWR_MUTE = 8'h11;
  localparam logic [7:0] IDX_STATUS = 8'h12;
  localparam int REG_W = 9;
  // field positions
  localparam int OSR_BIT = 6;
  localparam int RX_LOW_W = 6;
  localparam int SEL_W = 2;
  localparam int MAP_LO = 0;
  localparam int ZFS_LO = 4;
  localparam int IZD_BIT = 7;
  localparam int MUTE_LO = 3;
  // reset values
  localparam logic [8:0] RST_RX_OSR = 9'h00a;
  localparam logic [8:0] RST_ROUTE = 9'h024;
  localparam logic [8:0] RST_MAP_ZF = 9'h009;
  localparam logic [8:0] RST_PWR_MUTE = 9'h000;
  // lane select codes
  localparam logic [1:0] SEL_LANE1 = 2'h0;
  localparam logic [1:0] SEL_LANE2 = 2'h1;
  localparam logic [1:0] SEL_LANE3 = 2'h2;
  // output map pair codes
  localparam logic [1:0] MAP_MUTE = 2'h0;
  localparam logic [1:0] MAP_LEFT = 2'h1;
  localparam logic [1:0] MAP_RIGHT = 2'h2;
  localparam logic [1:0] MAP_AVG = 2'h3;
  // zero flag source codes
  localparam logic [2:0] ZFS_ALL = 3'h0;
  localparam logic [2:0] ZFS_DAC1 = 3'h1;
  localparam logic [2:0] ZFS_DAC2 = 3'h2;
  localparam logic [2:0] ZFS_DAC3 = 3'h3;
  // consecutive zero samples before a detector asserts
  localparam int ZERO_RUN = 1024;
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 32;
endpackage

// ### dzr_zero_detect.sv
// counts consecutive zero samples on one channel
module dzr_zero_detect #(
  parameter int W = 24,
  parameter int LIMIT = 1024
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sampleValid,
  input wire logic [W-1:0] sample,
  output logic zeroRun,
  output logic zeroNext
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] count_q;
  logic isZero;

  assign isZero = (sample == '0);
  // this sample completes or continues a run; used for instant automute
  assign zeroNext = isZero && (count_q >= LIM - CW'(1));

  // saturating run counter, cleared by any non-zero sample
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_q <= '0;
    end else if (sampleValid) begin
      if (!isZero) begin
        count_q <= '0;
      end else if (count_q != LIM) begin
        count_q <= count_q + CW'(1);
      end
    end
  end

  assign zeroRun = (count_q == LIM);
endmodule

// ### dzr_fifo.sv
// flop based fifo with valid/ready on both sides
module dzr_fifo #(
  parameter int WIDTH = 144,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != FULL);
  assign outValid = (count_q != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_q[rdPtr_q];

  // storage, written by index
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
      end
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// ### dzr_front_asserts.sv
// checker for the dac front: register effects, zero flags, stream handshake
module dzr_front_chk #(
  parameter int SW = 24,
  parameter int GPO_W = 4,
  parameter int ZERO_RUN = 1024
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic [6*SW-1:0] lanes,
  input wire logic dacValid,
  input wire logic dacReady,
  input wire logic [6*SW-1:0] dacData,
  input wire logic oversampleRateSelect,
  input wire logic [2:0] converterPowerDown,
  input wire logic [2:0] converterSoftMute,
  input wire logic zeroIndicator,
  input wire logic [GPO_W-1:0] generalOutputPins
);
  logic wrOk;
  logic take;
  logic [2:0] zfs_q;
  logic [3:0] force_q;
  int zeroCnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // pready is tied high, so the access cycle is the commit cycle
  assign wrOk = psel && penable && pwrite && paddr[1:0] == 2'h0;
  assign take = sampleValid && sampleReady;
  // shadow of the flag source field
  always_ff @(posedge mclk) begin
    if (reset) zfs_q <= 3'h0;
    else if (wrOk && paddr[9:2] == dzr_pkg::IDX_MAP_ZF) zfs_q <= pwdata[6:4];
  end
  // forced flags one edge late, as the pin lags its cause by a clock
  always_ff @(posedge mclk) begin
    if (reset) force_q <= 4'h0;
    else force_q <= {converterPowerDown | converterSoftMute,
                     &(converterPowerDown | converterSoftMute)};
  end
  // run of frames with every lane zero, whatever the routing
  always_ff @(posedge mclk) begin
    if (reset) zeroCnt_q <= 0;
    else if (take && |lanes) zeroCnt_q <= 0;
    else if (take && zeroCnt_q < ZERO_RUN) zeroCnt_q <= zeroCnt_q + 1;
  end
  osr_write_a: assert property (
    wrOk && paddr[9:2] == dzr_pkg::IDX_RX_OSR
    |=> oversampleRateSelect == $past(pwdata[6]))
    else $error("oversample bit not written");
  pd_mute_write_a: assert property (
    wrOk && paddr[9:2] == dzr_pkg::IDX_PWR_MUTE |=>
    {converterSoftMute, converterPowerDown} == $past(pwdata[5:0]))
    else $error("power-down or mute not written");
  gpo_copy_a: assert property (
    generalOutputPins == {GPO_W{zeroIndicator}})
    else $error("output pins differ from flag");
  zf_forced_low_a: assert property (
    zfs_q[2] && $past(zfs_q[2]) |-> !zeroIndicator)
    else $error("flag not forced low");
  zf_dac_forced_a: assert property (
    zfs_q != 3'h0 && !zfs_q[2] && $stable(zfs_q) && force_q[zfs_q[1:0]]
    |-> zeroIndicator)
    else $error("dac flag not set by power-down or mute");
  zf_all_forced_a: assert property (
    zfs_q == 3'h0 && $stable(zfs_q) && force_q[0] |-> zeroIndicator)
    else $error("combined flag not set");
  zf_run_a: assert property (
    zeroCnt_q == ZERO_RUN && $past(zeroCnt_q) == ZERO_RUN && !zfs_q[2]
    && $stable(zfs_q) |-> zeroIndicator)
    else $error("zero run did not raise flag");
  take_valid_a: assert property (
    take |=> dacValid)
    else $error("taken frame not presented");
  out_hold_a: assert property (
    dacValid && !dacReady |=> dacValid && $stable(dacData))
    else $error("stalled frame changed");
  cover property (take && !(|lanes));
  cover property ($rose(zeroIndicator));
  cover property (dacValid && !sampleReady);
endmodule

bind dzr_dac_front dzr_front_chk #(.SW(SW), .GPO_W(GPO_W),
  .ZERO_RUN(ZERO_RUN)) i_chk (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sampleValid(sampleValid), .sampleReady(sampleReady),
  .lanes({serialInLaneThreeRight, serialInLaneThreeLeft,
    serialInLaneTwoRight, serialInLaneTwoLeft,
    serialInLaneOneRight, serialInLaneOneLeft}),
  .dacValid(dacValid), .dacReady(dacReady), .dacData(dacData),
  .oversampleRateSelect(oversampleRateSelect),
  .converterPowerDown(converterPowerDown),
  .converterSoftMute(converterSoftMute), .zeroIndicator(zeroIndicator),
  .generalOutputPins(generalOutputPins));

// ### dzr_rx_model.sv
// audio receiver model: offers one stereo frame per lane per request
module dzr_rx_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic go,
  input wire logic [143:0] frame,
  input wire logic sampleReady,
  output logic sampleValid,
  output logic [143:0] lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  // frame held until taken; lanes then invert so stale data never looks valid
  always_ff @(posedge mclk) begin
    if (reset) begin
      sampleValid <= 1'b0;
      lanes <= '0;
    end else if (sampleValid && sampleReady) begin
      sampleValid <= 1'b0;
      lanes <= ~lanes;
    end else if (go && !sampleValid) begin
      sampleValid <= 1'b1;
      lanes <= frame;
    end
  end
endmodule

// ### dzr_dac_front_test.sv
// testbench for the dac routing, mapping and zero flag block
module dzr_dac_front_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RUN = 8;
  // lane3 R,L lane2 R,L lane1 R,L; values chosen to overflow a plain sum
  localparam logic [143:0] LN = {24'hff_fffe, 24'h00_0003, 24'h80_0002,
    24'h80_0000, 24'h7f_fffd, 24'h7f_ffff};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dacReady = 1'b1;
  logic go = 1'b0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [143:0] frame = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slvErr, sampleValid, sampleReady, dacValid, osr, zi;
  logic [143:0] lanes, dacData;
  logic [2:0] pd, mute;
  logic [3:0] general_output_pins;
  logic [12:0] rows [7] = '{13'h1224, 13'h1e2a, 13'h1e00, 13'h0c15,
    13'h0631, 13'h1806, 13'h0024};
  int err_count = 0;
  int n_tests = 0;
  int n, i, z, p;

  always #5 mclk = ~mclk;

  dzr_dac_front #(.ZERO_RUN(RUN)) i_dut (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .serialInLaneOneLeft(lanes[23:0]), .serialInLaneOneRight(lanes[47:24]),
    .serialInLaneTwoLeft(lanes[71:48]), .serialInLaneTwoRight(lanes[95:72]),
    .serialInLaneThreeLeft(lanes[119:96]),
    .serialInLaneThreeRight(lanes[143:120]), .dacValid(dacValid),
    .dacReady(dacReady), .dacData(dacData), .oversampleRateSelect(osr),
    .converterPowerDown(pd), .converterSoftMute(mute), .zeroIndicator(zi),
    .generalOutputPins(general_output_pins));

  dzr_rx_model i_src (.mclk(mclk), .reset(reset), .go(go), .frame(frame),
    .sampleReady(sampleReady), .sampleValid(sampleValid), .lanes(lanes));

  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++k < 20);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // hand one frame to the receiver model, return when it is presented
  task automatic send(input logic [143:0] f);
    int k;
    @(posedge mclk);
    frame <= f;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    k = 0;
    do @(negedge mclk); while (dacValid !== 1'b1 && ++k < 20);
  endtask

  function automatic logic [23:0] pick(input logic [1:0] c,
      input logic [23:0] l, input logic [23:0] r);
    logic [24:0] s;
    s = {l[23], l} + {r[23], r};
    case (c)
      2'h0: return 24'h00_0000;
      2'h1: return l;
      2'h2: return r;
      default: return s[24:1];
    endcase
  endfunction

  function automatic logic [143:0] expFrame(input logic [8:0] route,
      input logic [3:0] map, input logic [143:0] ln);
    logic [143:0] e;
    logic [47:0] pr;
    for (int d = 0; d < 3; d++) begin
      pr = route[2*d+:2] == 2'h3 ? 48'h0 : ln[48*route[2*d+:2]+:48];
      e[48*d+:48] = {pick(map[3:2], pr[23:0], pr[47:24]),
        pick(map[1:0], pr[23:0], pr[47:24])};
    end
    return e;
  endfunction

  // the whole run is a few hundred cycles
  initial begin
    #200us;
    err_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check({osr, zi, general_output_pins, pd, mute}, 0);
    apb(0, dzr_pkg::IDX_RX_OSR, 0);
    check(rd, 32'h0000_000a);
    apb(0, dzr_pkg::IDX_ROUTE, 0);
    check(rd, 32'h0000_0024);
    apb(0, dzr_pkg::IDX_MAP_ZF, 0);
    check(rd, 32'h0000_0009);
    // routing and mapping table
    for (i = 0; i < 7; i++) begin
      apb(1, dzr_pkg::IDX_ROUTE, 32'(rows[i][8:0]));
      apb(1, dzr_pkg::IDX_MAP_ZF, 32'(rows[i][12:9]));
      send(LN);
      check(dacData, expFrame(rows[i][8:0], rows[i][12:9], LN));
    end
    // unmapped place refused
    apb(1, 8'h13, 32'h0000_01ff);
    check(slvErr, 1'b1);
    apb(0, 8'h13, 0);
    check({slvErr, rd}, 33'h1_0000_0000);
    // 64x for a low clock ratio
    apb(1, dzr_pkg::IDX_RX_OSR, 32'h0000_004a);
    @(negedge mclk);
    check(osr, 1'b1);
    // zero run on dac1 with automute on
    apb(1, dzr_pkg::IDX_ROUTE, 32'h0000_0024);
    apb(1, dzr_pkg::IDX_MAP_ZF, 32'h0000_0099);
    for (i = 0; i < RUN - 1; i++) send('0);
    @(negedge mclk);
    check(zi, 1'b0);
    send('0);
    @(negedge mclk);
    check({zi, general_output_pins}, 5'h1f);
    apb(0, dzr_pkg::IDX_STATUS, 0);
    check(rd, 32'h0000_0fff);
    send(144'h1);
    check(dacData, 144'h1);
    @(negedge mclk);
    check(zi, 1'b0);
    apb(0, dzr_pkg::IDX_STATUS, 0);
    check(rd, 32'h0000_0fb6);
    // forced flags against every source code
    send(LN);
    for (p = 0; p < 2; p++) begin
      apb(1, dzr_pkg::IDX_PWR_MUTE, p ? 32'h0000_0038 : 32'h0000_0003);
      @(negedge mclk);
      check({mute, pd}, p ? 6'h38 : 6'h03);
      for (z = 0; z < 8; z++) begin
        apb(1, dzr_pkg::IDX_MAP_ZF, {25'h0, 3'(z), 4'h9});
        repeat (2) @(negedge mclk);
        check(zi, z == 0 ? p : (z < 4 ? (z < 3 || p) : 0));
      end
    end
    // fill the buffer while the consumer stalls, then drain it
    dacReady <= 1'b0;
    for (i = 0; i < 33; i++) begin
      @(posedge mclk);
      frame <= {120'h0, 24'(i + 1)};
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
    end
    @(negedge mclk);
    check({sampleReady, dacValid, sampleValid}, 3'h3);
    @(posedge mclk);
    dacReady <= 1'b1;
    n = 0;
    // looked at mid-cycle, away from the edge that pops the head
    repeat (40) begin
      @(negedge mclk);
      if (dacValid === 1'b1) begin
        n++;
        check(dacData[23:0], n);
      end
    end
    check(n, 33);
    // reset again in mid-run: controls and map return to defaults
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    apb(0, dzr_pkg::IDX_MAP_ZF, 0);
    check(rd, 32'h0000_0009);
    check({osr, pd, mute}, 7'h00);
    results();
  end
endmodule
